// ### logic/asr_pkg.sv
`default_nettype none
package asr_pkg;
    // ****************************************************************
    // bus shape
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;
    localparam int IDX_LSB = 2;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL = 10'h00B;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_FLAGS_ONE = 10'h00C;
    localparam logic [IDX_W-1:0] IDX_RECEIVE_STATUS_CONTROL = 10'h018;
    localparam logic [IDX_W-1:0] IDX_TRANSMIT_DATA = 10'h019;
    localparam logic [IDX_W-1:0] IDX_RECEIVE_DATA = 10'h01A;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_ENABLES_ONE = 10'h08C;
    localparam logic [IDX_W-1:0] IDX_TRANSMIT_STATUS_CONTROL = 10'h098;
    localparam logic [IDX_W-1:0] IDX_BAUD_DIVISOR = 10'h099;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int B_RX_INTERRUPT_ENABLE = 5;
    localparam int B_SERIAL_PORT_ENABLE = 7;
    localparam int B_NINE_BIT_RECEIVE_SELECT = 6;
    localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int B_ADDRESS_MATCH_ENABLE = 3;
    localparam int B_SYNCHRONOUS_SELECT = 4;
    localparam int B_HIGH_SPEED_BAUD_SELECT = 2;
    localparam int RECEIVE_STATUS_CONTROL_CTL_LSB = 3;

    // ****************************************************************
    // reset values and masks
    // ****************************************************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
    localparam logic [7:0] SHIFT_REGISTER_EMPTY_MASK = 8'h02;
    localparam logic [7:0] TRANSMIT_STATUS_CONTROL_WMASK = 8'hF5;
    localparam logic [7:0] PIE_WMASK = 8'h7F;
    localparam logic [7:0] RX_AVAILABLE_MASK = 8'h20;

    // ****************************************************************
    // timing counts
    // ****************************************************************
    localparam logic [3:0] PH_FIRST_SMP = 4'h7;
    localparam logic [3:0] PH_MID = 4'h9;
    localparam logic [3:0] PH_LAST = 4'hF;
    localparam logic [1:0] LO_SPEED_LAST = 2'h3;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_DATA = 4'h4,
        ST_STOP = 4'h8
    } asr_state_e;
endpackage : asr_pkg
`default_nettype wire

// ### logic/asr_top.sv
//Contract
// - line sampled at sixteen times bit rate
// - frames accepted only with continuous receive
// - word moves to buffer at middle of stop bit
// - available flag set when buffer holds word
// - flag clears when reads empty the buffer
// - interrupt request gated by receive interrupt enable bit
// - buffer is two entries deep
// - full buffer at stop sets overrun, drops
// - overrun clears only by re-enabling receive
// - overrun blocks all further transfers into the buffer
// - low stop bit sets framing error
// - error and ninth bit stored per entry
// - nine-bit select gives nine data bits
// - nine-bit address mode buffers only address words
// - data buffer at 1Ah, reads zero reset
// - transmit status resets with empty bit set
// - start, eight/nine data LSB first, stop
// - baud clock sixteen or sixty-four times
`timescale 1ns/1ps
`default_nettype none
module asr_top (
    input wire logic mclk_i,                          // 40 MHz clock
    input wire logic nrst_i,                          // async reset, low
    input wire logic psel_i,                          // apb select
    input wire logic penable_i,                       // apb enable
    input wire logic pwrite_i,                        // apb write
    input wire logic [asr_pkg::ADDR_W-1:0] paddr_i,   // apb byte address
    input wire logic [asr_pkg::DATA_W-1:0] pwdata_i,  // apb write data
    output logic [asr_pkg::DATA_W-1:0] prdata_o,      // apb read data
    output logic pready_o,                            // apb ready
    output logic pslverr_o,                           // apb error
    input wire logic receive_pin_i,                   // serial line in
    output logic rx_irq_o                             // received word irq
);
    import asr_pkg::*;

    // ****************************************************************
    // reset release and line synchroniser
    // ****************************************************************
    logic rst_s1_reg, rst_n;
    logic rx_s1_reg, rx_s2_reg, rx_prev_reg;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_s1_reg <= receive_pin_i;
            rx_s2_reg <= rx_s1_reg;
            rx_prev_reg <= rx_s2_reg;
        end
    end

    // ****************************************************************
    // register storage and apb decode
    // ****************************************************************
    logic [7:0] intctl_reg, pie_reg, txdata_reg, transmit_status_control_reg, baud_divisor_reg;
    logic [4:0] receive_status_control_ctl_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic pslverr_reg, pop_arm_reg;
    logic [1:0] count_reg;
    logic overrun_error_flag_reg;
    logic [9:0] head;

    wire [IDX_W-1:0] idx = paddr_i[ADDR_W-1:IDX_LSB];
    wire hit_ic = (idx == IDX_INTERRUPT_CONTROL);
    wire hit_pf = (idx == IDX_PERIPHERAL_FLAGS_ONE);
    wire hit_rs = (idx == IDX_RECEIVE_STATUS_CONTROL);
    wire hit_td = (idx == IDX_TRANSMIT_DATA);
    wire hit_rd = (idx == IDX_RECEIVE_DATA);
    wire hit_pe = (idx == IDX_PERIPHERAL_ENABLES_ONE);
    wire hit_ts = (idx == IDX_TRANSMIT_STATUS_CONTROL);
    wire hit_bd = (idx == IDX_BAUD_DIVISOR);
    wire mapped = hit_ic | hit_pf | hit_rs | hit_td | hit_rd | hit_pe
                | hit_ts | hit_bd;
    wire setup = psel_i & ~penable_i;
    wire wr_acc = psel_i & penable_i & pwrite_i & mapped;
    wire rd_acc = psel_i & penable_i & ~pwrite_i;
    wire [7:0] wbyte = pwdata_i[7:0];

    wire avail = (count_reg != 2'h0);
    wire [7:0] pf_rd = avail ? RX_AVAILABLE_MASK : RST_ZERO;
    // framing error and ninth bits follow the entry at the head of the buffer
    wire [7:0] rs_rd = {receive_status_control_ctl_reg, head[9], overrun_error_flag_reg, head[8]};
    wire [7:0] rd_word =
        hit_ic ? intctl_reg :
        hit_pf ? pf_rd :
        hit_rs ? rs_rd :
        hit_td ? txdata_reg :
        hit_rd ? head[7:0] :
        hit_pe ? pie_reg :
        hit_ts ? transmit_status_control_reg :
        hit_bd ? baud_divisor_reg : RST_ZERO;
    // pop only a word that was visible when the read was set up
    wire pop = rd_acc & pop_arm_reg;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
            pop_arm_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= {24'h00_0000, rd_word};
            pslverr_reg <= ~mapped;
            pop_arm_reg <= hit_rd & ~pwrite_i & avail;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            intctl_reg <= RST_ZERO;
            pie_reg <= RST_ZERO;
            txdata_reg <= RST_ZERO;
            transmit_status_control_reg <= RST_TRANSMIT_STATUS_CONTROL;
            baud_divisor_reg <= RST_ZERO;
            receive_status_control_ctl_reg <= 5'h00;
        end else if (wr_acc) begin
            if (hit_ic) intctl_reg <= wbyte;
            if (hit_pe) pie_reg <= wbyte & PIE_WMASK;
            if (hit_td) txdata_reg <= wbyte;
            // transmitter absent: its shifter always reads empty
            if (hit_ts) transmit_status_control_reg <= (wbyte & TRANSMIT_STATUS_CONTROL_WMASK)
                                   | SHIFT_REGISTER_EMPTY_MASK;
            if (hit_bd) baud_divisor_reg <= wbyte;
            if (hit_rs) receive_status_control_ctl_reg <= wbyte[7:RECEIVE_STATUS_CONTROL_CTL_LSB];
        end
    end

    assign prdata_o = prdata_reg;
    assign pslverr_o = pslverr_reg;
    assign pready_o = 1'b1;
    assign rx_irq_o = avail & pie_reg[B_RX_INTERRUPT_ENABLE];

    // ****************************************************************
    // baud generator and x16 sample tick
    // ****************************************************************
    wire [7:0] receive_status_control_v = {receive_status_control_ctl_reg, 3'h0};
    wire serial_port_enable = receive_status_control_v[B_SERIAL_PORT_ENABLE];
    wire rx9 = receive_status_control_v[B_NINE_BIT_RECEIVE_SELECT];
    wire continuous_receive_enable = receive_status_control_v[B_CONTINUOUS_RECEIVE_ENABLE];
    wire address_match_enable = receive_status_control_v[B_ADDRESS_MATCH_ENABLE];
    wire sync_sel = transmit_status_control_reg[B_SYNCHRONOUS_SELECT];
    wire high_speed_baud_select = transmit_status_control_reg[B_HIGH_SPEED_BAUD_SELECT];
    wire rx_en = serial_port_enable & continuous_receive_enable & ~sync_sel;

    logic [7:0] brg_cnt_reg;
    logic [1:0] pre_reg;
    wire brg_tick = rx_en & (brg_cnt_reg == 8'h00);
    // low speed: four baud ticks per sample gives x64 base
    wire smp_tick = brg_tick & (high_speed_baud_select | (pre_reg == LO_SPEED_LAST));

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            brg_cnt_reg <= 8'h00;
            pre_reg <= 2'h0;
        end else if (!rx_en) begin
            brg_cnt_reg <= 8'h00;
            pre_reg <= 2'h0;
        end else if (brg_tick) begin
            brg_cnt_reg <= baud_divisor_reg;
            pre_reg <= pre_reg + 2'h1;
        end else begin
            brg_cnt_reg <= brg_cnt_reg - 8'h01;
        end
    end

    // ****************************************************************
    // frame recovery
    // ****************************************************************
    asr_state_e state_reg, state_next;
    logic [3:0] phase_reg, bitn_reg;
    logic [1:0] smp_reg;
    logic [8:0] shift_reg;

    wire a0 = smp_reg[0];
    wire a1 = smp_reg[1];
    wire maj = (a0 & a1) | (a0 & rx_s2_reg) | (a1 & rx_s2_reg);
    wire bit_mid = smp_tick & (phase_reg == PH_MID);
    wire bit_end = smp_tick & (phase_reg == PH_LAST);
    wire start_edge = rx_prev_reg & ~rx_s2_reg;
    wire [3:0] last_bit = rx9 ? LAST_BIT_9 : LAST_BIT_8;
    wire done = (state_reg == ST_STOP) & bit_mid;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_edge & ~overrun_error_flag_reg) state_next = ST_START;
            end
            ST_START: begin
                if (bit_mid & maj) state_next = ST_IDLE;
                else if (bit_end) state_next = ST_DATA;
            end
            ST_DATA: begin
                if (bit_end & (bitn_reg == last_bit)) state_next = ST_STOP;
            end
            ST_STOP: begin
                if (bit_mid) state_next = ST_IDLE;
            end
        endcase
        if (!rx_en) state_next = ST_IDLE;
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 4'h0;
            smp_reg <= 2'h3;
        end else if (state_reg == ST_IDLE) begin
            phase_reg <= 4'h0;
        end else if (smp_tick) begin
            phase_reg <= phase_reg + 4'h1;
            if (phase_reg >= PH_FIRST_SMP) smp_reg <= {a0, rx_s2_reg};
        end
    end

    // data bits enter at the top, so the first bit ends lowest
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 9'h000;
            bitn_reg <= 4'h0;
        end else if (state_reg != ST_DATA) begin
            bitn_reg <= 4'h0;
        end else begin
            if (bit_mid) shift_reg <= {maj, shift_reg[8:1]};
            if (bit_end) bitn_reg <= bitn_reg + 4'h1;
        end
    end

    wire ninth = rx9 & shift_reg[8];
    wire [7:0] wdata = rx9 ? shift_reg[7:0] : shift_reg[8:1];
    wire framing_error_flag_bit = ~maj;
    wire drop = address_match_enable & rx9 & ~ninth;
    wire take = done & ~overrun_error_flag_reg & ~drop;
    wire full = (count_reg == FIFO_DEPTH);
    wire push = take & ~full;
    wire ovr = take & full;

    // ****************************************************************
    // two-entry receive buffer
    // ****************************************************************
    logic [9:0] mem_reg [2];
    logic wr_ptr_reg, rd_ptr_reg;

    genvar e;
    generate
        for (e = 0; e < 2; e++) begin : g_ent
            always_ff @(posedge mclk_i or negedge rst_n) begin
                if (!rst_n) begin
                    mem_reg[e] <= 10'h000;
                end else if (push && (wr_ptr_reg == 1'(e))) begin
                    mem_reg[e] <= {framing_error_flag_bit, ninth, wdata};
                end
            end
        end
    endgenerate

    assign head = avail ? mem_reg[rd_ptr_reg] : 10'h000;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
            if (push & ~pop) count_reg <= count_reg + 2'h1;
            else if (pop & ~push) count_reg <= count_reg - 2'h1;
        end
    end

    // clearing continuous receive resets the error
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            overrun_error_flag_reg <= 1'b0;
        end else if (!continuous_receive_enable) begin
            overrun_error_flag_reg <= 1'b0;
        end else if (ovr) begin
            overrun_error_flag_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    sequence s_full_stop;
        done && full && !overrun_error_flag_reg && !drop && !pop;
    endsequence
    property p_overrun;
        s_full_stop |=> overrun_error_flag_reg && (count_reg == $past(count_reg));
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged on full buffer");

    property p_depth;
        count_reg <= FIFO_DEPTH;
    endproperty
    a_depth: assert property (p_depth)
        else $error("buffer holds more than two words");

    property p_irq;
        rx_irq_o |-> avail && pie_reg[B_RX_INTERRUPT_ENABLE];
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq without enable or word");

    property p_irq_push;
        push |=> rx_irq_o == pie_reg[B_RX_INTERRUPT_ENABLE];
    endproperty
    a_irq_push: assert property (p_irq_push)
        else $error("irq does not follow enable after push");

    property p_overrun_error_flag_hold;
        overrun_error_flag_reg && continuous_receive_enable |=> overrun_error_flag_reg;
    endproperty
    a_overrun_error_flag_hold: assert property (p_overrun_error_flag_hold)
        else $error("overrun cleared without re-enable");

    property p_overrun_error_flag_clear;
        !continuous_receive_enable |=> !overrun_error_flag_reg;
    endproperty
    a_overrun_error_flag_clear: assert property (p_overrun_error_flag_clear)
        else $error("overrun not cleared by disable");

    property p_block;
        overrun_error_flag_reg |=> count_reg <= $past(count_reg);
    endproperty
    a_block: assert property (p_block)
        else $error("word accepted while overrun");

    property p_push;
        done && !full && !overrun_error_flag_reg && !drop && !pop
            |=> count_reg == $past(count_reg) + 2'h1;
    endproperty
    a_push: assert property (p_push)
        else $error("received word not buffered");

    property p_framing_error_flag;
        done && !maj && !drop && !overrun_error_flag_reg && !full
            |=> mem_reg[$past(wr_ptr_reg)][9] && avail;
    endproperty
    a_framing_error_flag: assert property (p_framing_error_flag)
        else $error("framing error not reported");

    property p_addr_drop;
        done && drop && !pop |=> $stable(count_reg);
    endproperty
    a_addr_drop: assert property (p_addr_drop)
        else $error("data word buffered in address mode");

    property p_gate;
        !rx_en |=> state_reg == ST_IDLE;
    endproperty
    a_gate: assert property (p_gate)
        else $error("receiver active while disabled");

    property p_pop;
        pop && !push |=> count_reg == $past(count_reg) - 2'h1;
    endproperty
    a_pop: assert property (p_pop)
        else $error("read did not drain buffer");
endmodule : asr_top
`default_nettype wire

// ### tb/asr_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_tx_model (
    input wire logic mclk_i, // bench clock
    output logic line_o      // serial line towards receiver
);
    // ****************************************************************
    // remote transmitter, idle high, changes just after rising edges
    // ****************************************************************
    initial line_o = 1'b1;

    task automatic put(input logic v, input int bc);
        line_o <= v;
        repeat (bc) @(posedge mclk_i);
    endtask : put

    task automatic send(input logic [8:0] word, input logic nine,
                        input int bc, input logic stop);
        put(1'b0, bc);
        for (int i = 0; i < 8; i++) begin
            put(word[i], bc);
        end
        if (nine) begin
            put(word[8], bc);
        end
        put(stop, bc);
        line_o <= 1'b1;
    endtask : send

    // short low pulse that must not be taken as a start bit
    task automatic glitch(input int lo, input int idle);
        put(1'b0, lo);
        put(1'b1, idle);
    endtask : glitch
endmodule : asr_tx_model
`default_nettype wire

// ### tb/test_async_serial_receiver.sv
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_receiver;
    import asr_pkg::*;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    localparam logic [11:0] A_PF = {IDX_PERIPHERAL_FLAGS_ONE, 2'b00};
    localparam logic [11:0] A_RCS = {IDX_RECEIVE_STATUS_CONTROL, 2'b00};
    localparam logic [11:0] A_RD = {IDX_RECEIVE_DATA, 2'b00};
    localparam logic [11:0] A_PIE = {IDX_PERIPHERAL_ENABLES_ONE, 2'b00};
    localparam logic [11:0] A_TXS = {IDX_TRANSMIT_STATUS_CONTROL, 2'b00};
    typedef struct {
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic err;
    } asr_row_s;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_line;
    logic rx_irq;
    logic [31:0] rd;
    logic er;
    int checks = 0;
    int mismatches = 0;
    asr_row_s rows [18] = '{
        '{1'b0, A_RD, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, A_TXS, 32'h0000_0000, 32'h0000_0002, 1'b0},
        '{1'b0, A_PF, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, A_RCS, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h02C, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, A_PIE, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h264, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h064, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, A_TXS, 32'h0000_00FF, 32'h0000_00F7, 1'b0},
        '{1'b1, A_PF, 32'h0000_00FF, 32'h0000_0000, 1'b0},
        '{1'b1, A_RD, 32'h0000_00FF, 32'h0000_0000, 1'b0},
        '{1'b1, 12'h004, 32'h0000_00FF, 32'h0000_0000, 1'b1},
        '{1'b1, 12'h064, 32'h0000_00A5, 32'h0000_00A5, 1'b0},
        '{1'b1, A_PIE, 32'h0000_00FF, 32'h0000_007F, 1'b0},
        '{1'b1, A_PIE, 32'h0000_0020, 32'h0000_0020, 1'b0},
        '{1'b1, 12'h02C, 32'h0000_00C0, 32'h0000_00C0, 1'b0},
        '{1'b1, 12'h264, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, A_TXS, 32'h0000_0004, 32'h0000_0006, 1'b0}
    };

    always #12.5 mclk = ~mclk;

    asr_top i_asr_top (
        .mclk_i(mclk),
        .nrst_i(nrst),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .receive_pin_i(rx_line),
        .rx_irq_o(rx_irq)
    );

    asr_tx_model i_asr_tx_model (
        .mclk_i(mclk),
        .line_o(rx_line)
    );

    // ****************************************************************
    // bus, compare and closing tasks
    // ****************************************************************
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rdat, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task chk(input string nm, input logic [31:0] seen,
             input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, er);
        chk($sformatf("reg %h", a), rd, exp);
    endtask : rchk

    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d}, rd, er);
    endtask : wr

    task frame(input logic [8:0] w, input logic nine, input int bc,
               input logic stp);
        i_asr_tx_model.send(w, nine, bc, stp);
        repeat (8) @(posedge mclk);
    endtask : frame

    task close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        close_out();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (rows[i]) begin
            if (rows[i].wr) apb(1'b1, rows[i].addr, rows[i].wdata, rd, er);
            rchk(rows[i].addr, rows[i].exp);
            chk("pslverr", {31'h0, er}, {31'h0, rows[i].err});
        end
        wr(A_RCS, 8'h90);
        frame(9'h0A5, 1'b0, 16, 1'b1);
        chk("irq", {31'h0, rx_irq}, 32'h0000_0001);
        rchk(A_PF, 32'h0000_0020);
        rchk(A_RCS, 32'h0000_0090);
        rchk(A_RD, 32'h0000_00A5);
        rchk(A_PF, 32'h0000_0000);
        chk("irq", {31'h0, rx_irq}, 32'h0000_0000);
        wr(A_PIE, 8'h00);
        frame(9'h03C, 1'b0, 16, 1'b1);
        chk("irq", {31'h0, rx_irq}, 32'h0000_0000);
        rchk(A_RD, 32'h0000_003C);
        wr(A_PIE, 8'h20);
        frame(9'h011, 1'b0, 16, 1'b1);
        frame(9'h022, 1'b0, 16, 1'b0);
        rchk(A_RCS, 32'h0000_0090);
        rchk(A_RD, 32'h0000_0011);
        rchk(A_PF, 32'h0000_0020);
        rchk(A_RCS, 32'h0000_0094);
        rchk(A_RD, 32'h0000_0022);
        rchk(A_PF, 32'h0000_0000);
        frame(9'h001, 1'b0, 16, 1'b1);
        frame(9'h002, 1'b0, 16, 1'b1);
        frame(9'h003, 1'b0, 16, 1'b1);
        rchk(A_RCS, 32'h0000_0092);
        frame(9'h004, 1'b0, 16, 1'b1);
        rchk(A_RD, 32'h0000_0001);
        rchk(A_RD, 32'h0000_0002);
        rchk(A_PF, 32'h0000_0000);
        wr(A_RCS, 8'h90);
        rchk(A_RCS, 32'h0000_0092);
        wr(A_RCS, 8'h80);
        wr(A_RCS, 8'h90);
        rchk(A_RCS, 32'h0000_0090);
        frame(9'h055, 1'b0, 16, 1'b1);
        rchk(A_RD, 32'h0000_0055);
        wr(A_RCS, 8'h80);
        frame(9'h066, 1'b0, 16, 1'b1);
        rchk(A_PF, 32'h0000_0000);
        wr(A_RCS, 8'hD0);
        frame(9'h13C, 1'b1, 16, 1'b1);
        frame(9'h05A, 1'b1, 16, 1'b1);
        rchk(A_RCS, 32'h0000_00D1);
        rchk(A_RD, 32'h0000_003C);
        rchk(A_RCS, 32'h0000_00D0);
        rchk(A_RD, 32'h0000_005A);
        wr(A_RCS, 8'hD8);
        frame(9'h077, 1'b1, 16, 1'b1);
        rchk(A_PF, 32'h0000_0000);
        frame(9'h142, 1'b1, 16, 1'b1);
        rchk(A_RCS, 32'h0000_00D9);
        rchk(A_RD, 32'h0000_0042);
        wr(A_RCS, 8'hD0);
        frame(9'h066, 1'b1, 16, 1'b1);
        rchk(A_RCS, 32'h0000_00D0);
        rchk(A_RD, 32'h0000_0066);
        wr(A_RCS, 8'h90);
        i_asr_tx_model.glitch(4, 40);
        rchk(A_PF, 32'h0000_0000);
        wr(A_TXS, 8'h14);
        frame(9'h033, 1'b0, 16, 1'b1);
        rchk(A_PF, 32'h0000_0000);
        wr(A_TXS, 8'h00);
        frame(9'h096, 1'b0, 64, 1'b1);
        rchk(A_RD, 32'h0000_0096);
        wr(12'h264, 8'h01);
        wr(A_TXS, 8'h04);
        frame(9'h0C3, 1'b0, 32, 1'b1);
        rchk(A_RD, 32'h0000_00C3);
        frame(9'h03C, 1'b0, 32, 1'b1);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk(A_RD, 32'h0000_0000);
        rchk(A_TXS, 32'h0000_0002);
        close_out();
    end
endmodule : test_async_serial_receiver
`default_nettype wire
